// ---- verilog/esq_defines.vh ----
// constants for the extended sequencer register bank
// Notes on behaviour
// - index port selects, data port accesses register
// - low nibble 0110 in key unlocks bank
// - memory-mapped only mode ignores port accesses
// - memory pin bit7 requests two-clock writes
// - synth control two bit7 enables two-clock writes
// - feature pixel bit0 selects external video clock
// - feature pixel bit1 latches pixels on external clock
// - feature pixel bits 7-4 pick colour mode
// - feature sync bit0 enables feature connector
// - feature sync bit1 selects local pixel bus
// - sync bits control hsync and vsync power states
// - bit0 loads new memory clock dividers
// - bit1 loads new dot clock dividers
// - bit5 loads both dividers immediately
// - bit3 makes video clock direction follow input
// - synth control one bit4 clears synth counters
// - palette bit1 resets, bit0 enables test counter
// - palette bit6 selects one-cycle table write
// - palette bit7 enables clock-doubled mode
`ifndef ESQ_DEFINES_VH
`define ESQ_DEFINES_VH
`define ESQ_IDX_UNLOCK      5'h08
`define ESQ_IDX_IO_DECODE   5'h09
`define ESQ_IDX_MEM_PIN     5'h0A
`define ESQ_IDX_FEAT_PIX    5'h0B
`define ESQ_IDX_FEAT_SYNC   5'h0D
`define ESQ_IDX_MCLK_LOW    5'h10
`define ESQ_IDX_MCLK_HIGH   5'h11
`define ESQ_IDX_DOT_CLOCK_LOW    5'h12
`define ESQ_IDX_DOT_CLOCK_HIGH   5'h13
`define ESQ_IDX_SYNTH_ONE   5'h14
`define ESQ_IDX_SYNTH_TWO   5'h15
`define ESQ_IDX_TEST_A      5'h16
`define ESQ_IDX_TEST_B      5'h17
`define ESQ_IDX_PAL_CLK     5'h18
`define ESQ_IDX_PIN_SEL     5'h1C
`define ESQ_UNLOCK_CODE     4'h6
`define ESQ_REG_RESET       8'h00
`define ESQ_BIT_MMIO_ONLY   7
`define ESQ_BIT_TWO_MCLK    7
`define ESQ_BIT_VCLK_DOT    0
`define ESQ_BIT_VCLK_LATCH  1
`define ESQ_BIT_FEAT_EN     0
`define ESQ_BIT_LPB_SEL     1
`define ESQ_BIT_CLR_CNT     4
`define ESQ_BIT_LOAD_MCLK   0
`define ESQ_BIT_LOAD_DOT_CLOCK   1
`define ESQ_BIT_VCLK_DIR    3
`define ESQ_BIT_DOT_CLOCK_DIV2   4
`define ESQ_BIT_LOAD_NOW    5
`define ESQ_BIT_DOT_CLOCK_INV    6
`define ESQ_BIT_TCNT_EN     0
`define ESQ_BIT_TCNT_RST    1
`define ESQ_BIT_LUT_ONE     6
`define ESQ_BIT_DAC_DBL     7
`define ESQ_TCNT_W          8
`endif

// ---- verilog/esq_test_counter.v ----
// palette dac test counter with reset and enable
`timescale 1ns/10ps
module esq_test_counter
#(
   parameter W = 8
)
(
   clk_sys,
   nrst,
   ce,
   clr,
   en,
   count
);
   input          clk_sys;
   input          nrst;
   input          ce;
   input          clr;
   input          en;
   output [W-1:0] count;
   reg    [W-1:0] cnt_ff;
   reg    [W-1:0] nxt_cnt;
   assign count = cnt_ff;
   always @*
   begin
      nxt_cnt = cnt_ff;
      if (clr)
         nxt_cnt = {W{1'b0}};
      else if (en)
         nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
   end
   always @(posedge clk_sys)
   begin
      if (!nrst)
         cnt_ff <= {W{1'b0}};
      else if (ce)
         cnt_ff <= nxt_cnt;
   end
endmodule // esq_test_counter

// ---- verilog/esq_regs.v ----
// extended sequencer register bank behind the indexed port pair
`timescale 1ns/10ps
`include "esq_defines.vh"
module esq_regs
#(
   parameter TCNT_W = `ESQ_TCNT_W
)
(
   input  wire              clk_sys,
   input  wire              nrst,
   input  wire              ce,
   input  wire              pio_idx_wr,
   input  wire              pio_data_wr,
   input  wire              pio_data_rd,
   input  wire              mmio_wr,
   input  wire              mmio_rd,
   input  wire [4:0]        mmio_idx,
   input  wire [7:0]        wdata,
   input  wire              video_clock_dir_input,
   output reg  [7:0]        rdata_ff,
   output reg               rvalid_ff,
   output reg  [4:0]        seq_index_ff,
   output reg               unlocked_ff,
   output reg               two_mclk_write_ff,
   output reg               dot_clk_from_ext_ff,
   output reg               feat_latch_ext_ff,
   output reg  [3:0]        feat_colour_mode_ff,
   output reg               feat_enable_ff,
   output reg               local_pixel_bus_ff,
   output reg  [1:0]        hsync_power_ff,
   output reg  [1:0]        vsync_power_ff,
   output reg  [7:0]        mclk_low_act_ff,
   output reg  [7:0]        mclk_high_act_ff,
   output reg  [7:0]        dot_clock_low_act_ff,
   output reg  [7:0]        dot_clock_high_act_ff,
   output reg               mclk_load_ff,
   output reg               dot_clock_load_ff,
   output reg               vclk_out_en_n_ff,
   output reg               dot_clk_div2_ff,
   output reg               dot_clk_invert_ff,
   output reg               synth_cnt_clr_ff,
   output reg               lut_one_cycle_ff,
   output reg               dac_clk_double_ff,
   output reg  [TCNT_W-1:0] dac_test_count_ff
);
   reg  [7:0] key_ff;
   reg  [7:0] io_dec_ff;
   reg  [7:0] mem_pin_ff;
   reg  [7:0] feat_pix_ff;
   reg  [7:0] feat_sync_ff;
   reg  [7:0] mclk_low_ff;
   reg  [7:0] mclk_high_ff;
   reg  [7:0] dot_clock_low_ff;
   reg  [7:0] dot_clock_high_ff;
   reg  [7:0] synth_one_ff;
   reg  [7:0] synth_two_ff;
   reg  [7:0] test_a_ff;
   reg  [7:0] test_b_ff;
   reg  [7:0] pal_clk_ff;
   reg  [7:0] pin_sel_ff;
   reg  [7:0] nxt_rdata;
   wire [TCNT_W-1:0] tcnt;
   wire       mmio_only;
   wire       port_ok;
   wire       acc_wr;
   wire       acc_rd;
   wire [4:0] acc_idx;
   wire       unlocked;
   wire       load_now;
   wire       mload;
   wire       dload;

   // is the index one of the lockable extended registers
   function is_ext;
      input [4:0] idx;
      begin
         is_ext = (idx >= `ESQ_IDX_IO_DECODE);
      end
   endfunction

   // write strobe for one index, gated by the lock
   function hit;
      input [4:0] idx;
      input [4:0] want;
      input       wr;
      input       unl;
      begin
         hit = wr && (idx == want) && (unl || !is_ext(want));
      end
   endfunction

   assign mmio_only = io_dec_ff[`ESQ_BIT_MMIO_ONLY];
   assign port_ok   = !mmio_only;
   assign acc_wr    = mmio_wr || (pio_data_wr && port_ok);
   assign acc_rd    = mmio_rd || (pio_data_rd && port_ok);
   assign acc_idx   = mmio_wr || mmio_rd ? mmio_idx : seq_index_ff;
   assign unlocked  = (key_ff[3:0] == `ESQ_UNLOCK_CODE);
   assign load_now  = synth_two_ff[`ESQ_BIT_LOAD_NOW];
   // immediate mode follows every divider write, not only a load request
   assign mload = synth_two_ff[`ESQ_BIT_LOAD_MCLK] ||
                  load_now;
   assign dload = synth_two_ff[`ESQ_BIT_LOAD_DOT_CLOCK] ||
                  load_now;

   esq_test_counter #(.W(TCNT_W)) u_tcnt
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ce      (ce),
      .clr     (pal_clk_ff[`ESQ_BIT_TCNT_RST]),
      .en      (pal_clk_ff[`ESQ_BIT_TCNT_EN]),
      .count   (tcnt)
   );

   // read mux; locked extended registers read as zero
   always @*
   begin
      nxt_rdata = 8'h00;
      if (!is_ext(acc_idx) || unlocked)
      begin
         case (acc_idx)
            `ESQ_IDX_UNLOCK:    nxt_rdata = key_ff;
            `ESQ_IDX_IO_DECODE: nxt_rdata = io_dec_ff;
            `ESQ_IDX_MEM_PIN:   nxt_rdata = mem_pin_ff;
            `ESQ_IDX_FEAT_PIX:  nxt_rdata = feat_pix_ff;
            `ESQ_IDX_FEAT_SYNC: nxt_rdata = feat_sync_ff;
            `ESQ_IDX_MCLK_LOW:  nxt_rdata = mclk_low_ff;
            `ESQ_IDX_MCLK_HIGH: nxt_rdata = mclk_high_ff;
            `ESQ_IDX_DOT_CLOCK_LOW:  nxt_rdata = dot_clock_low_ff;
            `ESQ_IDX_DOT_CLOCK_HIGH: nxt_rdata = dot_clock_high_ff;
            `ESQ_IDX_SYNTH_ONE: nxt_rdata = synth_one_ff;
            `ESQ_IDX_SYNTH_TWO: nxt_rdata = synth_two_ff;
            `ESQ_IDX_TEST_A:    nxt_rdata = test_a_ff;
            `ESQ_IDX_TEST_B:    nxt_rdata = test_b_ff;
            `ESQ_IDX_PAL_CLK:   nxt_rdata = pal_clk_ff;
            `ESQ_IDX_PIN_SEL:   nxt_rdata = pin_sel_ff;
            default:            nxt_rdata = 8'h00;
         endcase
      end
   end

   // host side registers
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         seq_index_ff <= 5'h00;
         key_ff       <= `ESQ_REG_RESET;
         io_dec_ff    <= `ESQ_REG_RESET;
         mem_pin_ff   <= `ESQ_REG_RESET;
         feat_pix_ff  <= `ESQ_REG_RESET;
         feat_sync_ff <= `ESQ_REG_RESET;
         mclk_low_ff  <= `ESQ_REG_RESET;
         mclk_high_ff <= `ESQ_REG_RESET;
         dot_clock_low_ff  <= `ESQ_REG_RESET;
         dot_clock_high_ff <= `ESQ_REG_RESET;
         synth_one_ff <= `ESQ_REG_RESET;
         synth_two_ff <= `ESQ_REG_RESET;
         test_a_ff    <= `ESQ_REG_RESET;
         test_b_ff    <= `ESQ_REG_RESET;
         pal_clk_ff   <= `ESQ_REG_RESET;
         pin_sel_ff   <= `ESQ_REG_RESET;
         rdata_ff     <= 8'h00;
         rvalid_ff    <= 1'b0;
      end
      else if (ce)
      begin
         if (pio_idx_wr && port_ok)
            seq_index_ff <= wdata[4:0];
         rvalid_ff <= acc_rd;
         if (acc_rd)
            rdata_ff <= nxt_rdata;
         if (hit(acc_idx, `ESQ_IDX_UNLOCK, acc_wr, unlocked))
            key_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_IO_DECODE, acc_wr, unlocked))
            io_dec_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_MEM_PIN, acc_wr, unlocked))
            mem_pin_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_FEAT_PIX, acc_wr, unlocked))
            feat_pix_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_FEAT_SYNC, acc_wr, unlocked))
            feat_sync_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_MCLK_LOW, acc_wr, unlocked))
            mclk_low_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_MCLK_HIGH, acc_wr, unlocked))
            mclk_high_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_DOT_CLOCK_LOW, acc_wr, unlocked))
            dot_clock_low_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_DOT_CLOCK_HIGH, acc_wr, unlocked))
            dot_clock_high_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_SYNTH_ONE, acc_wr, unlocked))
            synth_one_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_SYNTH_TWO, acc_wr, unlocked))
            synth_two_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_TEST_A, acc_wr, unlocked))
            test_a_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_TEST_B, acc_wr, unlocked))
            test_b_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_PAL_CLK, acc_wr, unlocked))
            pal_clk_ff <= wdata;
         if (hit(acc_idx, `ESQ_IDX_PIN_SEL, acc_wr, unlocked))
            pin_sel_ff <= wdata;
      end
   end

   // decoded controls, all registered so every output is a flop
   always @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         unlocked_ff         <= 1'b0;
         two_mclk_write_ff   <= 1'b0;
         dot_clk_from_ext_ff <= 1'b0;
         feat_latch_ext_ff   <= 1'b0;
         feat_colour_mode_ff <= 4'h0;
         feat_enable_ff      <= 1'b0;
         local_pixel_bus_ff  <= 1'b0;
         hsync_power_ff      <= 2'h0;
         vsync_power_ff      <= 2'h0;
         mclk_low_act_ff     <= `ESQ_REG_RESET;
         mclk_high_act_ff    <= `ESQ_REG_RESET;
         dot_clock_low_act_ff     <= `ESQ_REG_RESET;
         dot_clock_high_act_ff    <= `ESQ_REG_RESET;
         mclk_load_ff        <= 1'b0;
         dot_clock_load_ff        <= 1'b0;
         vclk_out_en_n_ff    <= 1'b1;
         dot_clk_div2_ff     <= 1'b0;
         dot_clk_invert_ff   <= 1'b0;
         synth_cnt_clr_ff    <= 1'b0;
         lut_one_cycle_ff    <= 1'b0;
         dac_clk_double_ff   <= 1'b0;
         dac_test_count_ff   <= {TCNT_W{1'b0}};
      end
      else if (ce)
      begin
         unlocked_ff <= unlocked;
         // both the memory pin bit and the synth enable must be set
         two_mclk_write_ff <= mem_pin_ff[`ESQ_BIT_TWO_MCLK] &&
                              synth_two_ff[`ESQ_BIT_TWO_MCLK];
         dot_clk_from_ext_ff <= feat_pix_ff[`ESQ_BIT_VCLK_DOT];
         feat_latch_ext_ff   <= feat_pix_ff[`ESQ_BIT_VCLK_LATCH];
         feat_colour_mode_ff <= feat_pix_ff[7:4];
         feat_enable_ff      <= feat_sync_ff[`ESQ_BIT_FEAT_EN];
         local_pixel_bus_ff  <= feat_sync_ff[`ESQ_BIT_LPB_SEL];
         hsync_power_ff      <= feat_sync_ff[5:4];
         vsync_power_ff      <= feat_sync_ff[7:6];
         mclk_load_ff        <= mload;
         dot_clock_load_ff        <= dload;
         if (mload)
         begin
            mclk_low_act_ff  <= mclk_low_ff;
            mclk_high_act_ff <= mclk_high_ff;
         end
         if (dload)
         begin
            dot_clock_low_act_ff  <= dot_clock_low_ff;
            dot_clock_high_act_ff <= dot_clock_high_ff;
         end
         // pin driven (enable low) unless direction follows the input and the input is high
         vclk_out_en_n_ff <= synth_two_ff[`ESQ_BIT_VCLK_DIR] &&
                             video_clock_dir_input;
         dot_clk_div2_ff   <= synth_two_ff[`ESQ_BIT_DOT_CLOCK_DIV2];
         dot_clk_invert_ff <= synth_two_ff[`ESQ_BIT_DOT_CLOCK_INV];
         synth_cnt_clr_ff  <= synth_one_ff[`ESQ_BIT_CLR_CNT];
         lut_one_cycle_ff  <= pal_clk_ff[`ESQ_BIT_LUT_ONE];
         dac_clk_double_ff <= pal_clk_ff[`ESQ_BIT_DAC_DBL];
         dac_test_count_ff <= tcnt;
      end
   end
endmodule // esq_regs

// ---- tb/esq_host.sv ----
// host model driving the indexed port pair and the memory-mapped path
`timescale 1ns/10ps
module esq_host
(
   input  wire       clk_sys,
   input  wire       rvalid_ff,
   input  wire [7:0] rdata_ff,
   output reg        pio_idx_wr  = 1'b0,
   output reg        pio_data_wr = 1'b0,
   output reg        pio_data_rd = 1'b0,
   output reg        mmio_wr     = 1'b0,
   output reg        mmio_rd     = 1'b0,
   output reg  [4:0] mmio_idx    = 5'h00,
   output reg  [7:0] wdata       = 8'h00
);
   // s: 0 index, 1 data write, 2 data read, 3 mmio write, 4 mmio read
   task strobe(input int s, input [4:0] i, input [7:0] d);
      @(posedge clk_sys);
      {pio_idx_wr, pio_data_wr, pio_data_rd, mmio_wr, mmio_rd} <= 5'h10 >> s;
      mmio_idx <= i;
      wdata <= (s == 0) ? {3'h0, i} : d;
      @(posedge clk_sys);
      {pio_idx_wr, pio_data_wr, pio_data_rd, mmio_wr, mmio_rd} <= 5'h00;
      // released data toggles so a stale byte never looks valid
      wdata <= ~wdata;
   endtask
   // extra edges let the decoded outputs settle before anyone looks
   task reg_wr(input int m, input [4:0] i, input [7:0] d);
      if (m == 0)
         strobe(0, i, d);
      strobe(m ? 3 : 1, i, d);
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task reg_rd(input int m, input [4:0] i, output [7:0] d, output ok);
      int n;
      d = 8'h00;
      ok = 1'b0;
      if (m == 0)
         strobe(0, i, 8'h00);
      strobe(m ? 4 : 2, i, 8'h00);
      for (n = 0; n < 4 && !ok; n = n + 1)
      begin
         #1;
         if (rvalid_ff === 1'b1)
         begin
            ok = 1'b1;
            d = rdata_ff;
         end
         @(posedge clk_sys);
      end
   endtask
endmodule // esq_host

// ---- tb/esq_regs_chk.sv ----
// assertions on the ports of the extended sequencer register bank
`timescale 1ns/10ps
module esq_regs_chk
#(
   parameter TCNT_W = 8
)
(
   input wire              clk_sys,
   input wire              nrst,
   input wire              ce,
   input wire              pio_data_wr,
   input wire              pio_data_rd,
   input wire              mmio_wr,
   input wire              mmio_rd,
   input wire              video_clock_dir_input,
   input wire              rvalid_ff,
   input wire              unlocked_ff,
   input wire              vclk_out_en_n_ff,
   input wire [7:0]        mclk_low_act_ff,
   input wire              mclk_load_ff,
   input wire [7:0]        dot_clock_low_act_ff,
   input wire              dot_clock_load_ff,
   input wire [3:0]        feat_colour_mode_ff,
   input wire [TCNT_W-1:0] dac_test_count_ff
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   AST_RD_ANSWER: assert property (
      mmio_rd && ce |=> rvalid_ff)
      else $error("read not answered");
   AST_RD_CAUSE: assert property (
      rvalid_ff && $past(ce) |-> $past(pio_data_rd || mmio_rd))
      else $error("read data without a read");
   AST_UNLOCK_CAUSE: assert property (
      $rose(unlocked_ff) |-> $past(pio_data_wr || mmio_wr, 2))
      else $error("unlock without a key write");
   AST_LOCK_HOLD: assert property (
      !unlocked_ff [*3] |=> $stable(feat_colour_mode_ff))
      else $error("locked bank changed");
   AST_VCLK_DIR: assert property (
      $past(nrst) && $past(ce) && !$past(video_clock_dir_input)
      |-> !vclk_out_en_n_ff)
      else $error("video clock pin not driven");
   AST_TCNT_STEP: assert property (
      $changed(dac_test_count_ff) |-> dac_test_count_ff == {TCNT_W{1'b0}} ||
      dac_test_count_ff == $past(dac_test_count_ff) +
                           {{(TCNT_W-1){1'b0}}, 1'b1})
      else $error("test counter jumped");
   AST_MCLK_LOAD: assert property (
      $changed(mclk_low_act_ff) |-> mclk_load_ff || $past(mclk_load_ff))
      else $error("memory clock loaded unasked");
   AST_DOT_CLOCK_LOAD: assert property (
      $changed(dot_clock_low_act_ff) |-> dot_clock_load_ff || $past(dot_clock_load_ff))
      else $error("dot clock loaded unasked");
endmodule // esq_regs_chk
bind esq_regs esq_regs_chk #(.TCNT_W(TCNT_W)) u_chk
(
   .clk_sys               (clk_sys),
   .nrst                  (nrst),
   .ce                    (ce),
   .pio_data_wr           (pio_data_wr),
   .pio_data_rd           (pio_data_rd),
   .mmio_wr               (mmio_wr),
   .mmio_rd               (mmio_rd),
   .video_clock_dir_input (video_clock_dir_input),
   .rvalid_ff             (rvalid_ff),
   .unlocked_ff           (unlocked_ff),
   .vclk_out_en_n_ff      (vclk_out_en_n_ff),
   .mclk_low_act_ff       (mclk_low_act_ff),
   .mclk_load_ff          (mclk_load_ff),
   .dot_clock_low_act_ff       (dot_clock_low_act_ff),
   .dot_clock_load_ff          (dot_clock_load_ff),
   .feat_colour_mode_ff   (feat_colour_mode_ff),
   .dac_test_count_ff     (dac_test_count_ff)
);

// ---- tb/tb.sv ----
// self-checking bench for the extended sequencer register bank
`timescale 1ns/10ps
module tb;
   reg        clk_sys, nrst, ce, video_clock_dir_input;
   wire       pio_idx_wr, pio_data_wr, pio_data_rd, mmio_wr, mmio_rd;
   wire [4:0] mmio_idx, seq_index_ff;
   wire [7:0] wdata, rdata_ff, dac_test_count_ff;
   wire [7:0] mclk_low_act_ff, mclk_high_act_ff;
   wire [7:0] dot_clock_low_act_ff, dot_clock_high_act_ff;
   wire [3:0] feat_colour_mode_ff;
   wire [1:0] hsync_power_ff, vsync_power_ff;
   wire       rvalid_ff, unlocked_ff, two_mclk_write_ff, feat_enable_ff;
   wire       dot_clk_from_ext_ff, feat_latch_ext_ff, local_pixel_bus_ff;
   wire       mclk_load_ff, dot_clock_load_ff, vclk_out_en_n_ff;
   wire       dot_clk_div2_ff, dot_clk_invert_ff, synth_cnt_clr_ff;
   wire       lut_one_cycle_ff, dac_clk_double_ff;
   integer    error_cnt, check_count;
   reg  [4:0] k;
   reg  [7:0] rd;
   reg        ok;

   esq_regs #(.TCNT_W(8)) u_dut
   (
      .clk_sys               (clk_sys),
      .nrst                  (nrst),
      .ce                    (ce),
      .pio_idx_wr            (pio_idx_wr),
      .pio_data_wr           (pio_data_wr),
      .pio_data_rd           (pio_data_rd),
      .mmio_wr               (mmio_wr),
      .mmio_rd               (mmio_rd),
      .mmio_idx              (mmio_idx),
      .wdata                 (wdata),
      .video_clock_dir_input (video_clock_dir_input),
      .rdata_ff              (rdata_ff),
      .rvalid_ff             (rvalid_ff),
      .seq_index_ff          (seq_index_ff),
      .unlocked_ff           (unlocked_ff),
      .two_mclk_write_ff     (two_mclk_write_ff),
      .dot_clk_from_ext_ff   (dot_clk_from_ext_ff),
      .feat_latch_ext_ff     (feat_latch_ext_ff),
      .feat_colour_mode_ff   (feat_colour_mode_ff),
      .feat_enable_ff        (feat_enable_ff),
      .local_pixel_bus_ff    (local_pixel_bus_ff),
      .hsync_power_ff        (hsync_power_ff),
      .vsync_power_ff        (vsync_power_ff),
      .mclk_low_act_ff       (mclk_low_act_ff),
      .mclk_high_act_ff      (mclk_high_act_ff),
      .dot_clock_low_act_ff       (dot_clock_low_act_ff),
      .dot_clock_high_act_ff      (dot_clock_high_act_ff),
      .mclk_load_ff          (mclk_load_ff),
      .dot_clock_load_ff          (dot_clock_load_ff),
      .vclk_out_en_n_ff      (vclk_out_en_n_ff),
      .dot_clk_div2_ff       (dot_clk_div2_ff),
      .dot_clk_invert_ff     (dot_clk_invert_ff),
      .synth_cnt_clr_ff      (synth_cnt_clr_ff),
      .lut_one_cycle_ff      (lut_one_cycle_ff),
      .dac_clk_double_ff     (dac_clk_double_ff),
      .dac_test_count_ff     (dac_test_count_ff)
   );
   esq_host u_host
   (
      .clk_sys     (clk_sys),
      .rvalid_ff   (rvalid_ff),
      .rdata_ff    (rdata_ff),
      .pio_idx_wr  (pio_idx_wr),
      .pio_data_wr (pio_data_wr),
      .pio_data_rd (pio_data_rd),
      .mmio_wr     (mmio_wr),
      .mmio_rd     (mmio_rd),
      .mmio_idx    (mmio_idx),
      .wdata       (wdata)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      check_count = check_count + 1;
      if (s !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   task rchk(input int m, input [4:0] i, input [7:0] e);
      u_host.reg_rd(m, i, rd, ok);
      chk("rvalid", {7'h00, ok}, 8'h01);
      chk("rdata", rd, e);
   endtask

   task tally_and_finish;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      error_cnt = 0;
      check_count = 0;
      nrst <= 1'b0;
      ce <= 1'b1;
      video_clock_dir_input <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      #1;
      chk("unlocked", {7'h00, unlocked_ff}, 8'h00);
      chk("vclk_en_n", {7'h00, vclk_out_en_n_ff}, 8'h01);
      u_host.reg_wr(0, 5'h0B, 8'hCB);
      chk("index", {3'h0, seq_index_ff}, 8'h0B);
      rchk(0, 5'h0B, 8'h00);
      chk("ext_video_clock_in_dot", {7'h00, dot_clk_from_ext_ff}, 8'h00);
      u_host.reg_wr(0, 5'h08, 8'h67);
      chk("unlocked", {7'h00, unlocked_ff}, 8'h00);
      u_host.reg_wr(0, 5'h08, 8'hA6);
      chk("unlocked", {7'h00, unlocked_ff}, 8'h01);
      rchk(0, 5'h08, 8'hA6);
      $display("test lock done");
      for (k = 5'h0A; k <= 5'h1C; k = k + 5'h01)
         u_host.reg_wr(0, k, {3'h6, k});
      for (k = 5'h0A; k <= 5'h1C; k = k + 5'h01)
         rchk(0, k, (k inside {5'h0A, 5'h0B, 5'h0D, [5'h10:5'h18], 5'h1C})
                    ? {3'h6, k} : 8'h00);
      chk("two_mclk", {7'h00, two_mclk_write_ff}, 8'h01);
      chk("ext_video_clock_in_dot", {7'h00, dot_clk_from_ext_ff}, 8'h01);
      chk("ext_video_clock_in_latch", {7'h00, feat_latch_ext_ff}, 8'h01);
      chk("colour", {4'h0, feat_colour_mode_ff}, 8'h0C);
      chk("feat_en", {7'h00, feat_enable_ff}, 8'h01);
      chk("lpb", {7'h00, local_pixel_bus_ff}, 8'h00);
      chk("sync", {4'h0, hsync_power_ff, vsync_power_ff}, 8'h03);
      chk("mclk_lo", mclk_low_act_ff, 8'hD0);
      chk("mclk_hi", mclk_high_act_ff, 8'hD1);
      chk("dot_clock_lo", dot_clock_low_act_ff, 8'h00);
      chk("div2", {7'h00, dot_clk_div2_ff}, 8'h01);
      chk("invert", {7'h00, dot_clk_invert_ff}, 8'h01);
      chk("vclk_en_n", {7'h00, vclk_out_en_n_ff}, 8'h00);
      chk("cnt_clr", {7'h00, synth_cnt_clr_ff}, 8'h01);
      chk("lut_one", {7'h00, lut_one_cycle_ff}, 8'h01);
      chk("dac_dbl", {7'h00, dac_clk_double_ff}, 8'h01);
      u_host.reg_wr(0, 5'h0D, 8'h32);
      chk("feat_en", {7'h00, feat_enable_ff}, 8'h00);
      chk("lpb", {7'h00, local_pixel_bus_ff}, 8'h01);
      chk("sync", {4'h0, hsync_power_ff, vsync_power_ff}, 8'h0C);
      $display("test bank done");
      u_host.reg_wr(0, 5'h15, 8'h02);
      chk("dot_clock_lo", dot_clock_low_act_ff, 8'hD2);
      chk("dot_clock_hi", dot_clock_high_act_ff, 8'hD3);
      chk("loads", {6'h00, mclk_load_ff, dot_clock_load_ff}, 8'h01);
      chk("two_mclk", {7'h00, two_mclk_write_ff}, 8'h00);
      u_host.reg_wr(0, 5'h15, 8'h00);
      u_host.reg_wr(0, 5'h10, 8'h11);
      chk("mclk_lo", mclk_low_act_ff, 8'hD0);
      u_host.reg_wr(0, 5'h15, 8'h20);
      chk("mclk_lo", mclk_low_act_ff, 8'h11);
      chk("loads", {6'h00, mclk_load_ff, dot_clock_load_ff}, 8'h03);
      u_host.reg_wr(0, 5'h15, 8'h08);
      chk("vclk_en_n", {7'h00, vclk_out_en_n_ff}, 8'h00);
      @(posedge clk_sys);
      video_clock_dir_input <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("vclk_en_n", {7'h00, vclk_out_en_n_ff}, 8'h01);
      u_host.reg_wr(0, 5'h18, 8'h01);
      repeat (8) @(posedge clk_sys);
      #1;
      chk("tcnt_run", dac_test_count_ff, 8'h0A);
      u_host.reg_wr(0, 5'h18, 8'h03);
      chk("tcnt_clr", dac_test_count_ff, 8'h00);
      $display("test clocks done");
      u_host.reg_wr(0, 5'h08, 8'h00);
      rchk(0, 5'h0B, 8'h00);
      u_host.reg_wr(0, 5'h0B, 8'h00);
      u_host.reg_wr(0, 5'h08, 8'h06);
      rchk(0, 5'h0B, 8'hCB);
      u_host.reg_wr(0, 5'h09, 8'h80);
      u_host.reg_wr(0, 5'h0B, 8'h00);
      rchk(1, 5'h0B, 8'hCB);
      u_host.reg_rd(0, 5'h0B, rd, ok);
      chk("pio_ignored", {7'h00, ok}, 8'h00);
      u_host.reg_wr(1, 5'h09, 8'h00);
      rchk(0, 5'h0B, 8'hCB);
      // a write while the clock enable is low must leave no trace
      @(posedge clk_sys);
      ce <= 1'b0;
      u_host.reg_wr(0, 5'h0B, 8'h5A);
      @(posedge clk_sys);
      ce <= 1'b1;
      rchk(0, 5'h0B, 8'hCB);
      $display("test decode done");
      tally_and_finish;
   end
endmodule // tb
